// ### display_point_search_tb.sv
/*
 * Self-checking bench of the display point search unit.
 * Assumes the storage model answers one cycle after each read.
 */
module display_point_search_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dps_pkg::*;
	logic       clk = 0;
	logic       srst = 1;
	logic       cv = 0;
	logic       hb = 0;
	logic       ht = 0;
	logic       lin = 0;
	logic       cpl = 0;
	logic       mmv = 0;
	logic [3:0] cmd = 0;
	logic [9:0] ax = 0;
	logic [9:0] ax2 = 0;
	logic [9:0] mx = 0;
	logic [7:0] ay = 0;
	logic [7:0] thr = 0;
	logic [7:0] my = 0;
	logic [1:0] ws = 0;
	logic       busy, srd, rv, rl, mset;
	logic [9:0] saddr, dx, rw, mxo, qx, qy, last_mx;
	logic [7:0] sdata, dy;
	int         num_errors = 0;
	int         n_checks = 0;
	int         n_mset = 0;

	always #5 clk = ~clk;

	dps_storage_model store (.i_clk(clk), .i_rd(srd), .i_addr(saddr), .o_data(sdata));

	dps_point_search dut (.i_clk(clk), .i_srst(srst), .i_cmd_valid(cv), .i_cmd(cmd),
		.i_arg_x(ax), .i_arg_x2(ax2), .i_arg_y(ay), .i_has_bounds(hb), .i_thr(thr),
		.i_has_thr(ht), .i_wave_sel(ws), .i_vertical_scale_lin(lin),
		.i_marker_dot_coupling(cpl), .i_marker_x(mx), .i_marker_y(my),
		.i_marker_moved(mmv), .i_store_data(sdata), .o_busy(busy), .o_store_rd(srd),
		.o_store_addr(saddr), .o_dot_x(dx), .o_dot_y(dy), .o_resp_valid(rv),
		.o_resp_last(rl), .o_resp_word(rw), .o_marker_set(mset), .o_marker_x(mxo));

	// Marker pulses last one cycle, so a monitor counts them.
	always @(posedge clk)
	begin
		if (mset === 1'b1)
		begin
			n_mset++;
			last_mx = mxo;
		end
	end

	////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	// Offers one command, then waits for idle while capturing query words.
	task automatic go(input cmd_e c, input logic [9:0] x = 0, input logic [9:0] x2 = 0,
		input logic [7:0] y = 0, input logic [7:0] t = 0, input logic b = 0);
		@(posedge clk);
		cmd <= 4'(c);
		ax <= x;
		ax2 <= x2;
		ay <= y;
		thr <= t;
		ht <= (t != 0);
		hb <= b;
		cv <= 1;
		@(posedge clk);
		cv <= 0;
		// A query that never answers must not pass on words left from an earlier one.
		qx = 'x;
		qy = 'x;
		for (int i = 0; i < 3000; i++)
		begin
			#1;
			if (rv === 1'b1 && rl === 1'b1)
				qy = rw;
			else if (rv === 1'b1)
				qx = rw;
			if (i >= 3 && busy === 1'b0)
				return;
			@(posedge clk);
		end
		num_errors++;
		tally_and_finish();
	endtask

	task automatic dot(input logic [9:0] x, input logic [7:0] y);
		check("dot_x", dx, x);
		check("dot_y", dy, y);
	endtask

	task automatic clear_mem();
		for (int i = 0; i < 1000; i++)
			store.mem[i] = 8'h00;
	endtask

	////////////////////////////////////////
	task automatic t_reset();
		dot(RESET_X_C, RESET_Y_C);
		go(CMD_QUERY);
		check("query_x", qx, 16'h01f4);
		check("query_y", qy, 16'h00e1);
		$display("reset test done");
	endtask

	task automatic t_set();
		go(CMD_SET_XY, 10'h001, , Y_BOTTOM_C);
		dot(X_LEFT_C, Y_BOTTOM_C);
		go(CMD_SET_XY, 10'h3e8, , Y_TOP_C);
		go(CMD_QUERY);
		check("query_x", qx, 16'h03e8);
		check("query_y", qy, 16'h00e1);
		store.mem[9] = 8'h5a;
		go(CMD_SET_X, 10'h00a);
		dot(10'h00a, 8'h5a);
		@(posedge clk);
		mx <= 10'h141;
		mmv <= 1;
		@(posedge clk);
		mmv <= 0;
		repeat (3) @(posedge clk);
		dot(10'h00a, 8'h5a);
		store.mem[999] = 8'h3c;
		go(CMD_SET_X, 10'h3e8);
		dot(10'h3e8, 8'h3c);
		$display("set test done");
	endtask

	task automatic t_extreme();
		for (int i = 0; i < 1000; i++)
			store.mem[i] = 8'h32;
		store.mem[99] = 8'hc8;
		store.mem[299] = 8'hc8;
		store.mem[499] = 8'h0a;
		store.mem[599] = 8'h0a;
		go(CMD_HIGHEST);
		dot(10'h064, 8'hc8);
		go(CMD_HIGHEST, 10'h190, 10'h0c8, , , 1);
		dot(10'h12c, 8'hc8);
		go(CMD_LOWEST);
		dot(10'h1f4, 8'h0a);
		$display("extreme test done");
	endtask

	task automatic t_peaks();
		clear_mem();
		store.mem[99] = 8'h78;
		store.mem[699] = 8'hb4;
		go(CMD_LARGEST);
		dot(10'h2bc, 8'hb4);
		go(CMD_LEFT, , , , 8'h64);
		dot(10'h064, 8'h78);
		go(CMD_LEFT, , , , 8'h64);
		dot(LEFT_NONE_X_C, NONE_Y_C);
		go(CMD_RIGHT, , , , 8'h64);
		dot(10'h064, 8'h78);
		go(CMD_RIGHT, , , , 8'h64);
		dot(10'h2bc, 8'hb4);
		go(CMD_RIGHT, , , , 8'h64);
		dot(RIGHT_NONE_X_C, NONE_Y_C);
		go(CMD_LARGEST, , , , 8'hc8);
		dot(BIG_NONE_X_C, NONE_Y_C);
		lin <= 1;
		go(CMD_LARGEST);
		check("lin_x", dx, 16'h02bc);
		check("lin_y", dy, 16'h00ed);
		lin <= 0;
		$display("peak test done");
	endtask

	task automatic t_half();
		clear_mem();
		store.mem[50] = 8'hf0;
		ws <= 2'h1;
		go(CMD_HIGHEST);
		dot(10'h065, 8'hf0);
		store.mem[560] = 8'hf1;
		ws <= 2'h2;
		go(CMD_HIGHEST);
		dot(10'h079, 8'hf1);
		ws <= 2'h0;
		$display("half test done");
	endtask

	task automatic t_marker();
		int n0;
		mx <= 10'h141;
		my <= 8'h4d;
		n0 = n_mset;
		go(CMD_MARKER_TO_DOT);
		dot(10'h141, 8'h4d);
		check("no_marker_set", 16'(n_mset - n0), 16'h0000);
		go(CMD_SET_XY, 10'h190, , 8'h64);
		go(CMD_DOT_TO_MARKER);
		check("marker_set", 16'(n_mset - n0), 16'h0001);
		check("marker_x", last_mx, 16'h0190);
		cpl <= 1;
		go(CMD_SET_XY, 10'h1c2, , 8'h64);
		check("coupled_set", 16'(n_mset - n0), 16'h0002);
		check("coupled_x", last_mx, 16'h01c2);
		@(posedge clk);
		mx  <= 10'h2a3;
		my  <= 8'h37;
		mmv <= 1;
		@(posedge clk);
		mmv <= 0;
		repeat (2) @(posedge clk);
		dot(10'h2a3, 8'h37);
		cpl <= 0;
		$display("marker test done");
	endtask

	////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		srst <= 0;
		t_reset();
		t_set();
		t_extreme();
		t_peaks();
		t_half();
		t_marker();
		tally_and_finish();
	end
endmodule // display_point_search_tb

// ### dps_pkg.sv
/*
 * Shared constants and types of the display point search unit.
 * Assumes a single 100 MHz system clock and screen-unit coordinates.
 */
package dps_pkg;

	localparam int X_W   = 10;
	localparam int Y_W   = 8;
	localparam int CNT_W = 11;

	// Horizontal scale is always a full record, whatever the source resolution.
	localparam logic [X_W-1:0] FULL_PTS_C  = 10'h3e8;
	localparam logic [X_W-1:0] HALF_PTS_C  = 10'h1f4;
	localparam logic [X_W-1:0] X_LEFT_C    = 10'h001;
	localparam logic [X_W-1:0] X_RIGHT_C   = 10'h3e8;

	// Screen edges and reset location.
	localparam logic [Y_W-1:0] Y_BOTTOM_C  = 8'h19;
	localparam logic [Y_W-1:0] Y_TOP_C     = 8'he1;
	localparam logic [X_W-1:0] RESET_X_C   = 10'h1f4;
	localparam logic [Y_W-1:0] RESET_Y_C   = 8'he1;

	// Locations reported when a peak search finds nothing, and the default threshold.
	localparam logic [X_W-1:0] BIG_NONE_X_C   = 10'h1f4;
	localparam logic [X_W-1:0] LEFT_NONE_X_C  = 10'h000;
	localparam logic [X_W-1:0] RIGHT_NONE_X_C = 10'h3e9;
	localparam logic [Y_W-1:0] NONE_Y_C       = 8'h00;
	localparam logic [Y_W-1:0] THR_DEFAULT_C  = 8'h00;

	// Sequencer counts: copy needs two cycles of storage latency, scan one flush.
	localparam logic [CNT_W-1:0] COPY_LAST_C = 11'h3e9;
	localparam logic [CNT_W-1:0] SCAN_LAST_C = 11'h3e9;

	typedef enum logic [1:0] {WAVE_FULL, WAVE_A, WAVE_B} wave_e;

	typedef enum logic [3:0] {
		CMD_SET_XY,
		CMD_SET_X,
		CMD_LARGEST,
		CMD_LEFT,
		CMD_RIGHT,
		CMD_HIGHEST,
		CMD_LOWEST,
		CMD_MARKER_TO_DOT,
		CMD_DOT_TO_MARKER,
		CMD_QUERY
	} cmd_e;

endpackage

// ### dps_point_search.sv
/*
 * Display point holder and waveform search engine.
 * Assumes the controller offers one command while o_busy is low and that
 * digital storage returns i_store_data the cycle after o_store_rd.
 */
// Contract
// R01 - Keep one X,Y location until an updating command runs.
// R02 - X always uses a 1000-point horizontal scale.
// R03 - Set with X and Y stores both values directly.
// R04 - Set with X only takes Y from the stored sample at X.
// R05 - Y 25 is bottom, 225 top; X 1 left, 1000 right.
// R06 - After reset the location is 500,225.
// R07 - Query returns X first, then Y.
// R08 - Largest peak above threshold; none found gives 500,0.
// R09 - Peak searches use threshold zero when none is given.
// R10 - Leftward search finds nearest peak left of X; else 0,0.
// R11 - Rightward search finds nearest peak right of X; else 1001,0.
// R12 - Highest search takes X and Y of the greatest sample.
// R13 - Lowest search takes X and Y of the smallest sample.
// R14 - Ties in extreme searches go to the leftmost sample.
// R15 - Extreme searches use optional X bounds, else 1 to 1000.
// R16 - Location and marker move apart unless coupling is on.
// R17 - Copy commands move location or marker without coupling.
// R18 - Half-resolution records are duplicated into a full buffer.
// R19 - Linear samples become logarithmic before peak searches.
// R20 - A peak exceeds threshold and is not below either neighbour.
module dps_point_search
(
	input  wire logic                      i_clk,
	input  wire logic                      i_srst,
	input  wire logic                      i_cmd_valid,
	input  wire logic [3:0]                i_cmd,
	input  wire logic [dps_pkg::X_W-1:0]   i_arg_x,
	input  wire logic [dps_pkg::X_W-1:0]   i_arg_x2,
	input  wire logic [dps_pkg::Y_W-1:0]   i_arg_y,
	input  wire logic                      i_has_bounds,
	input  wire logic [dps_pkg::Y_W-1:0]   i_thr,
	input  wire logic                      i_has_thr,
	input  wire logic [1:0]                i_wave_sel,
	input  wire logic                      i_vertical_scale_lin,
	input  wire logic                      i_marker_dot_coupling,
	input  wire logic [dps_pkg::X_W-1:0]   i_marker_x,
	input  wire logic [dps_pkg::Y_W-1:0]   i_marker_y,
	input  wire logic                      i_marker_moved,
	input  wire logic [dps_pkg::Y_W-1:0]   i_store_data,
	output logic                           o_busy,
	output logic                           o_store_rd,
	output logic      [dps_pkg::X_W-1:0]   o_store_addr,
	output logic      [dps_pkg::X_W-1:0]   o_dot_x,
	output logic      [dps_pkg::Y_W-1:0]   o_dot_y,
	output logic                           o_resp_valid,
	output logic                           o_resp_last,
	output logic      [dps_pkg::X_W-1:0]   o_resp_word,
	output logic                           o_marker_set,
	output logic      [dps_pkg::X_W-1:0]   o_marker_x
);
	import dps_pkg::*;

	////////////////////////////////////////////////////////////////////////////

	typedef enum logic [2:0] {S_IDLE, S_COPY, S_SCAN, S_PICK, S_RESP_Y} state_e;

	typedef struct packed
	{
		state_e           st;
		cmd_e             cmd;
		wave_e            wave;
		logic             lin;
		logic [CNT_W-1:0] cnt;
		logic [X_W-1:0]   dot_x;
		logic [Y_W-1:0]   dot_y;
		logic [Y_W-1:0]   thr;
		logic [X_W-1:0]   lo;
		logic [X_W-1:0]   hi;
		logic             found;
		logic [X_W-1:0]   best_x;
		logic [Y_W-1:0]   best_y;
		logic [Y_W-1:0]   w1;
		logic [Y_W-1:0]   w2;
		logic             busy;
		logic             store_rd;
		logic [X_W-1:0]   store_addr;
		logic             resp_valid;
		logic             resp_last;
		logic [X_W-1:0]   resp_word;
		logic             mk_set;
		logic [X_W-1:0]   mk_x;
	} state_s;

	state_s         r;
	state_s         n;
	logic           wr_en;
	logic [X_W-1:0] wr_addr;
	logic [Y_W-1:0] wr_data;
	logic [X_W-1:0] rd_addr;
	logic [Y_W-1:0] rd_data;
	logic [Y_W-1:0] s_in;
	logic [X_W-1:0] cx;
	logic [X_W-1:0] ix;
	logic [X_W-1:0] idx;
	logic           pk;
	logic           accept;

	// Coarse log: octave in the top three bits, five mantissa bits below.
	function automatic logic [Y_W-1:0] lin2log(input logic [Y_W-1:0] v);
		logic [2:0]     p;
		logic [Y_W-1:0] sh;
		p = 3'h0;
		for (int b = 0; b < Y_W; b++)
		begin
			if (v[b])
			begin
				p = 3'(b);
			end
		end
		sh = v << (3'h7 - p);
		return (v == 8'h00) ? 8'h00 : {p, sh[6:2]};
	endfunction

	////////////////////////////////////////////////////////////////////////////

	dps_wave_buffer u_buf
	(
		.i_clk     (i_clk),
		.i_srst    (i_srst),
		.i_wr_en   (wr_en),
		.i_wr_addr (wr_addr),
		.i_wr_data (wr_data),
		.i_rd_addr (rd_addr),
		.o_rd_data (rd_data)
	);

	assign accept = i_cmd_valid && (r.st == S_IDLE);

	always_comb
	begin
		n            = r;
		n.resp_valid = 1'b0;
		n.resp_last  = 1'b0;
		n.mk_set     = 1'b0;
		n.store_rd   = 1'b0;
		wr_en        = 1'b0;
		wr_addr      = '0;
		wr_data      = '0;
		rd_addr      = '0;
		s_in         = '0;
		pk           = 1'b0;
		cx           = r.cnt[X_W-1:0] - 10'h001;
		ix           = r.cnt[X_W-1:0];
		idx          = r.cnt[X_W-1:0] - 10'h002;
		case (r.st)
		S_IDLE:
		begin
			if (accept)
			begin
				n.cmd   = cmd_e'(i_cmd);
				n.wave  = wave_e'(i_wave_sel);
				n.lin   = i_vertical_scale_lin;
				n.cnt   = '0;
				n.found = 1'b0;
				n.w1    = '0;
				n.w2    = '0;
				n.thr   = i_has_thr ? i_thr : THR_DEFAULT_C; // [R09]
				n.lo    = X_LEFT_C; // [R15]
				n.hi    = X_RIGHT_C;
				if (i_has_bounds)
				begin
					n.lo = (i_arg_x < i_arg_x2) ? i_arg_x : i_arg_x2; // [R15]
					n.hi = (i_arg_x < i_arg_x2) ? i_arg_x2 : i_arg_x;
				end
				n.st   = S_COPY;
				n.busy = 1'b1;
				case (cmd_e'(i_cmd))
				CMD_SET_XY:
				begin
					n.dot_x = i_arg_x; // [R03]
					n.dot_y = i_arg_y;
					n.st    = S_IDLE;
					n.busy  = 1'b0;
				end
				CMD_SET_X:
				begin
					n.lo = i_arg_x; // [R04]
				end
				CMD_MARKER_TO_DOT:
				begin
					n.dot_x = i_marker_x; // [R17]
					n.dot_y = i_marker_y;
					n.st    = S_IDLE;
					n.busy  = 1'b0;
				end
				CMD_DOT_TO_MARKER:
				begin
					n.mk_set = 1'b1; // [R17]
					n.mk_x   = r.dot_x;
					n.st     = S_IDLE;
					n.busy   = 1'b0;
				end
				CMD_QUERY:
				begin
					n.resp_valid = 1'b1; // [R07]
					n.resp_word  = r.dot_x;
					n.st         = S_RESP_Y;
				end
				default:
				begin
				end
				endcase
				if (n.st == S_IDLE && i_marker_dot_coupling && cmd_e'(i_cmd) == CMD_SET_XY)
				begin
					n.mk_set = 1'b1; // [R16]
					n.mk_x   = i_arg_x;
				end
			end
			else if (i_marker_moved && i_marker_dot_coupling)
			begin
				n.dot_x = i_marker_x; // [R16]
				n.dot_y = i_marker_y;
			end
		end
		S_RESP_Y:
		begin
			n.resp_valid = 1'b1; // [R07]
			n.resp_last  = 1'b1;
			n.resp_word  = {2'b00, r.dot_y};
			n.st         = S_IDLE;
			n.busy       = 1'b0;
		end
		S_COPY:
		begin
			if (r.cnt < {1'b0, FULL_PTS_C})
			begin
				n.store_rd = 1'b1;
				case (r.wave) // [R18]
				WAVE_A:  n.store_addr = {1'b0, ix[X_W-1:1]};
				WAVE_B:  n.store_addr = HALF_PTS_C + {1'b0, ix[X_W-1:1]};
				default: n.store_addr = ix;
				endcase
			end
			if (r.cnt >= 11'h002)
			begin
				wr_en   = 1'b1;
				wr_addr = idx;
				wr_data = i_store_data;
				if (r.lin && (r.cmd == CMD_LARGEST || r.cmd == CMD_LEFT || r.cmd == CMD_RIGHT))
				begin
					wr_data = lin2log(i_store_data); // [R19]
				end
			end
			n.cnt = r.cnt + 11'h001;
			if (r.cnt == COPY_LAST_C)
			begin
				n.cnt = '0;
				n.st  = (r.cmd == CMD_SET_X) ? S_PICK : S_SCAN;
			end
		end
		S_PICK:
		begin
			// Out-of-scale X still reads the nearest edge sample.
			if (r.lo == 10'h000)
			begin
				rd_addr = '0;
			end
			else if (r.lo > FULL_PTS_C)
			begin
				rd_addr = FULL_PTS_C - 10'h001;
			end
			else
			begin
				rd_addr = r.lo - 10'h001; // [R02]
			end
			n.cnt = 11'h001;
			if (r.cnt == 11'h001)
			begin
				n.dot_x = r.lo; // [R04]
				n.dot_y = rd_data;
				n.st    = S_IDLE;
				n.busy  = 1'b0;
				if (i_marker_dot_coupling)
				begin
					n.mk_set = 1'b1; // [R16]
					n.mk_x   = r.lo;
				end
			end
		end
		S_SCAN:
		begin
			if (r.cnt < {1'b0, FULL_PTS_C})
			begin
				rd_addr = ix;
			end
			if (r.cnt >= 11'h001 && r.cnt <= {1'b0, FULL_PTS_C})
			begin
				s_in = rd_data;
				// Incoming sample sits at display X equal to cnt.
				if (ix >= r.lo && ix <= r.hi)
				begin
					if ((r.cmd == CMD_HIGHEST && (!r.found || s_in > r.best_y)) || // [R12] [R14]
						(r.cmd == CMD_LOWEST && (!r.found || s_in < r.best_y))) // [R13]
					begin
						n.found  = 1'b1;
						n.best_x = ix;
						n.best_y = s_in;
					end
				end
			end
			if (r.cnt >= 11'h002)
			begin
				pk = (r.w2 > r.thr) && (r.w2 >= r.w1) && (r.w2 >= s_in); // [R20]
				if (pk && ((r.cmd == CMD_LARGEST && (!r.found || r.w2 > r.best_y)) || // [R08]
					(r.cmd == CMD_LEFT && cx < r.dot_x) || // [R10]
					(r.cmd == CMD_RIGHT && cx > r.dot_x && !r.found))) // [R11]
				begin
					n.found  = 1'b1;
					n.best_x = cx;
					n.best_y = r.w2;
				end
			end
			n.w1  = r.w2;
			n.w2  = s_in;
			n.cnt = r.cnt + 11'h001;
			if (r.cnt == SCAN_LAST_C)
			begin
				n.st   = S_IDLE;
				n.busy = 1'b0;
				if (n.found)
				begin
					n.dot_x = n.best_x;
					n.dot_y = n.best_y;
				end
				else if (r.cmd == CMD_LARGEST || r.cmd == CMD_LEFT || r.cmd == CMD_RIGHT)
				begin
					n.dot_y = NONE_Y_C;
					n.dot_x = (r.cmd == CMD_LARGEST) ? BIG_NONE_X_C : // [R08]
						(r.cmd == CMD_LEFT) ? LEFT_NONE_X_C : RIGHT_NONE_X_C; // [R10] [R11]
				end
				if (i_marker_dot_coupling)
				begin
					n.mk_set = 1'b1; // [R16]
					n.mk_x   = n.dot_x;
				end
			end
		end
		default:
		begin
			n.st = S_IDLE;
		end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			r       <= '0;
			r.dot_x <= RESET_X_C; // [R06]
			r.dot_y <= RESET_Y_C; // [R05]
		end
		else
		begin
			r <= n; // [R01]
		end
	end

	assign o_busy       = r.busy;
	assign o_store_rd   = r.store_rd;
	assign o_store_addr = r.store_addr;
	assign o_dot_x      = r.dot_x;
	assign o_dot_y      = r.dot_y;
	assign o_resp_valid = r.resp_valid;
	assign o_resp_last  = r.resp_last;
	assign o_resp_word  = r.resp_word;
	assign o_marker_set = r.mk_set;
	assign o_marker_x   = r.mk_x;

	////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	sequence q_x_word;
		o_resp_valid && !o_resp_last && o_resp_word == $past(o_dot_x);
	endsequence

	sequence q_y_word;
		o_resp_valid && o_resp_last && o_resp_word == {2'b00, o_dot_y};
	endsequence

	logic scan_end;
	assign scan_end = (r.st == S_SCAN) && (r.cnt == SCAN_LAST_C) && !n.found;

	a_reset_point: assert property ($past(i_srst) |-> // [R06]
		o_dot_x == RESET_X_C && o_dot_y == RESET_Y_C && !o_busy)
		else $error("location not at reset value");

	a_hold_point: assert property ((r.st == S_IDLE && !i_cmd_valid && // [R01]
		!(i_marker_moved && i_marker_dot_coupling)) |=> $stable(o_dot_x) && $stable(o_dot_y))
		else $error("location changed without a command");

	a_set_direct: assert property ((accept && i_cmd == CMD_SET_XY) |=> // [R03]
		o_dot_x == $past(i_arg_x) && o_dot_y == $past(i_arg_y) && !o_busy)
		else $error("set with both values not stored");

	a_query_order: assert property ((accept && i_cmd == CMD_QUERY) |=> // [R07]
		q_x_word ##1 q_y_word ##1 !o_resp_valid)
		else $error("query words out of order");

	a_marker_copy: assert property ((accept && i_cmd == CMD_MARKER_TO_DOT) |=> // [R17]
		o_dot_x == $past(i_marker_x) && o_dot_y == $past(i_marker_y))
		else $error("marker not copied to location");

	a_dot_copy: assert property ((accept && i_cmd == CMD_DOT_TO_MARKER) |=> // [R17]
		o_marker_set && o_marker_x == o_dot_x && $stable(o_dot_x))
		else $error("location not copied to marker");

	a_marker_free: assert property (o_marker_set |-> $past(i_marker_dot_coupling) || // [R16]
		$past(accept && i_cmd == CMD_DOT_TO_MARKER))
		else $error("marker moved while uncoupled");

	a_left_miss: assert property ((scan_end && r.cmd == CMD_LEFT) |=> // [R10]
		o_dot_x == LEFT_NONE_X_C && o_dot_y == NONE_Y_C)
		else $error("failed left search gives wrong location");

	a_right_miss: assert property ((scan_end && r.cmd == CMD_RIGHT) |=> // [R11]
		o_dot_x == RIGHT_NONE_X_C && o_dot_y == NONE_Y_C)
		else $error("failed right search gives wrong location");

	a_big_miss: assert property ((scan_end && r.cmd == CMD_LARGEST) |=> // [R08]
		o_dot_x == BIG_NONE_X_C && o_dot_y == NONE_Y_C)
		else $error("failed largest search gives wrong location");

	a_extreme_range: assert property ((r.st == S_SCAN && r.found && // [R15]
		(r.cmd == CMD_HIGHEST || r.cmd == CMD_LOWEST)) |-> r.best_x >= r.lo && r.best_x <= r.hi)
		else $error("extreme search left its range");

	a_thr_default: assert property ((accept && !i_has_thr && i_cmd == CMD_LARGEST) |=> // [R09]
		r.thr == THR_DEFAULT_C)
		else $error("missing threshold not zero");

	a_half_map: assert property ((o_store_rd && r.wave == WAVE_A) |-> // [R18]
		o_store_addr < HALF_PTS_C)
		else $error("half record read outside its half");

endmodule // dps_point_search

// ### dps_storage_model.sv
/*
 * Behavioural digital storage that sits behind the point search unit.
 * Assumes the bench fills mem directly and that reads come from o_store_rd.
 */
module dps_storage_model
(
	input  wire logic                    i_clk,
	input  wire logic                    i_rd,
	input  wire logic [dps_pkg::X_W-1:0] i_addr,
	output logic      [dps_pkg::Y_W-1:0] o_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:999];
	initial o_data = 8'h00;
	// Between reads the line toggles, so stale data never passes for an answer.
	always @(posedge i_clk)
	begin
		if (i_rd)
			o_data <= mem[i_addr];
		else
			o_data <= ~o_data;
	end
endmodule // dps_storage_model

// ### dps_wave_buffer.sv
/*
 * Working buffer of one full 1000-sample record.
 * Assumes one write and one read per cycle; read data is registered.
 */
module dps_wave_buffer
(
	input  wire logic                      i_clk,
	input  wire logic                      i_srst,
	input  wire logic                      i_wr_en,
	input  wire logic [dps_pkg::X_W-1:0]   i_wr_addr,
	input  wire logic [dps_pkg::Y_W-1:0]   i_wr_data,
	input  wire logic [dps_pkg::X_W-1:0]   i_rd_addr,
	output logic      [dps_pkg::Y_W-1:0]   o_rd_data
);
	import dps_pkg::*;

	typedef struct packed
	{
		logic [Y_W-1:0] rd_data;
	} buf_s;

	logic [Y_W-1:0] mem [0:999];
	buf_s           r;
	buf_s           n;

	always_comb
	begin
		n         = r;
		n.rd_data = mem[i_rd_addr];
	end

	// The array itself is not reset; the copy phase always fills it first.
	always_ff @(posedge i_clk)
	begin
		if (i_wr_en)
		begin
			mem[i_wr_addr] <= i_wr_data;
		end
		if (i_srst)
		begin
			r <= '0;
		end
		else
		begin
			r <= n;
		end
	end

	assign o_rd_data = r.rd_data;

	a_buf_readback: assert property (@(posedge i_clk) disable iff (i_srst) // [R18]
		(i_wr_en ##1 (!i_wr_en && i_rd_addr == $past(i_wr_addr)))
		|=> o_rd_data == $past(i_wr_data, 2))
		else $error("buffer did not return the written sample");

endmodule // dps_wave_buffer
